// file: shared/ados_pkg.sv
/*
  Constants and types for the demultiplexed converter output stage.
  Assumes one sample clock and one converted sample word per rising edge.
*/
package ados_pkg;
  // Width of one converted sample word
  localparam int ADOS_SAMPLE_W = 10;
  // Sample-clock cycles from sampling edge to port update, interleaved mode
  localparam int ADOS_LAT_IL = 6;
  // Level of the half-rate clock right after the sync release edge
  localparam logic ADOS_HCLK_AT_SYNC = 1'b0;
  // Parity reset value: odd, so the first sample after reset is even
  localparam logic ADOS_PARITY_RST = 1'b1;
  localparam logic ADOS_PARITY_EVEN = 1'b0;

  typedef struct packed {
    logic valid;
    logic odd;
    logic [ADOS_SAMPLE_W-1:0] data;
  } ados_entry_t;

  localparam ados_entry_t ADOS_ENTRY_NONE = '0;
endpackage

// file: shared/ados_pipe_if.sv
/*
  Carrier between the output controller and its sample delay line.
  Assumes both ends run on the sample clock.
*/
`timescale 1ns/1ps
interface ados_pipe_if import ados_pkg::*; ();
  ados_entry_t head;
  ados_entry_t tail;
  logic flush;

  modport src (output head, output flush, input tail);
  modport dly (input head, input flush, output tail);
endinterface

// file: rtl/ados_delay_line.sv
/*
  Sample delay line: each tagged sample leaves DEPTH edges after it entered.
  Assumes the controller drives head and flush from the sample clock domain.
*/
`timescale 1ns/1ps
module ados_delay_line import ados_pkg::*; #(
  parameter int DEPTH = ADOS_LAT_IL
) (
  input wire logic clk_in,
  input wire logic rst_in,
  ados_pipe_if.dly pipe
);
  typedef struct packed {
    ados_entry_t [DEPTH-1:0] stage;
  } ados_dly_state_t;

  ados_dly_state_t st_q;
  ados_dly_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (pipe.flush) begin
      // Drop everything sampled before a hold so no stale word leaks out
      st_d.stage = '0;
    end else begin
      st_d.stage[0] = pipe.head;
      for (int i = 1; i < DEPTH; i++) begin
        st_d.stage[i] = st_q.stage[i-1];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pipe.tail = st_q.stage[DEPTH-1];
endmodule // ados_delay_line

// file: rtl/ados_top.sv
/*
  Demultiplexed output stage of a sampling converter: splits the sample
  stream over an even and an odd port, drives a half-rate capture clock and
  aligns the split on release of the sample-align hold input.
  Assumes clk_in is the sample clock and all inputs are synchronous to it.
*/
// Operation
// - Half-rate clock and complement driven out
// - Interleaved mode: six cycles latency per port
// - Parallel mode: odd port seven cycles latency
// - Parallel mode: odd port changes only together with even port
// - Hold high freezes ports and clock
// - Hold release edge marks the reference sample
// - Reference sample on even port after six
// - Next sample on odd port after six, seven in parallel mode
`timescale 1ns/1ps
module ados_top import ados_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADOS_SAMPLE_W-1:0] sample_in,
  input wire logic sample_align_hold_in,
  input wire logic parallel_mode_in,
  output logic [ADOS_SAMPLE_W-1:0] port_even_out,
  output logic [ADOS_SAMPLE_W-1:0] port_odd_out,
  output logic half_rate_clock_out,
  output logic half_rate_clock_n_out
);
  typedef struct packed {
    logic hold;
    logic parity;
    logic hclk;
    logic [ADOS_SAMPLE_W-1:0] even;
    logic [ADOS_SAMPLE_W-1:0] odd;
    ados_entry_t odd_extra;
  } ados_state_t;

  ados_state_t st_q;
  ados_state_t st_d;
  logic release_w;
  logic cur_odd;
  logic even_ld;
  logic odd_ld;
  ados_entry_t tail_w;

  ados_pipe_if pipe ();

  ados_delay_line #(
    .DEPTH(ADOS_LAT_IL)
  ) u_delay (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pipe(pipe.dly)
  );

  assign tail_w = pipe.tail;
  // First edge with hold low after it was high
  assign release_w = st_q.hold && !sample_align_hold_in;
  // Parity restarts at the release edge, then alternates
  assign cur_odd = release_w ? ADOS_PARITY_EVEN : !st_q.parity;

  always_comb begin
    pipe.head = ADOS_ENTRY_NONE;
    pipe.head.valid = !sample_align_hold_in;
    pipe.head.odd = cur_odd;
    pipe.head.data = sample_in;
    pipe.flush = sample_align_hold_in;
  end

  // Even samples always leave straight from the delay line
  assign even_ld = !sample_align_hold_in && tail_w.valid && !tail_w.odd;
  // Odd samples take the extra stage in parallel mode
  assign odd_ld = !sample_align_hold_in &&
                  (parallel_mode_in ? st_q.odd_extra.valid : (tail_w.valid && tail_w.odd));

  always_comb begin
    st_d = st_q;
    st_d.hold = sample_align_hold_in;
    st_d.parity = cur_odd;
    if (sample_align_hold_in) begin
      st_d.hclk = st_q.hclk;
    end else if (release_w) begin
      st_d.hclk = ADOS_HCLK_AT_SYNC;
    end else begin
      st_d.hclk = !st_q.hclk;
    end
    if (even_ld) begin
      st_d.even = tail_w.data;
    end
    if (odd_ld) begin
      st_d.odd = parallel_mode_in ? st_q.odd_extra.data : tail_w.data;
    end
    st_d.odd_extra = ADOS_ENTRY_NONE;
    if (!sample_align_hold_in && parallel_mode_in && tail_w.valid && tail_w.odd) begin
      st_d.odd_extra = tail_w;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q.hold <= 1'b0;
      st_q.parity <= ADOS_PARITY_RST;
      st_q.hclk <= ADOS_HCLK_AT_SYNC;
      st_q.even <= '0;
      st_q.odd <= '0;
      st_q.odd_extra <= ADOS_ENTRY_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign port_even_out = st_q.even;
  assign port_odd_out = st_q.odd;
  assign half_rate_clock_out = st_q.hclk;
  assign half_rate_clock_n_out = !st_q.hclk;

  // Checks

  property p_hclk_toggle;
    @(posedge clk_in) disable iff (rst_in)
      (!sample_align_hold_in && !release_w) |=>
        (half_rate_clock_out != $past(half_rate_clock_out)) &&
        (half_rate_clock_n_out == !half_rate_clock_out);
  endproperty
  a_hclk_toggle: assert property (p_hclk_toggle) else $error("half-rate clock failed to toggle");

  property p_il_even_latency;
    @(posedge clk_in) disable iff (rst_in)
      release_w ##1 (!sample_align_hold_in && !parallel_mode_in)[*7] |->
        port_even_out == $past(sample_in, 7);
  endproperty
  a_il_even_latency: assert property (p_il_even_latency) else $error("even port latency wrong");

  property p_il_odd_latency;
    @(posedge clk_in) disable iff (rst_in)
      (release_w && !parallel_mode_in) ##1 (!sample_align_hold_in && !parallel_mode_in)[*8] |->
        port_odd_out == $past(sample_in, 7);
  endproperty
  a_il_odd_latency: assert property (p_il_odd_latency) else $error("odd port latency wrong");

  property p_il_steady;
    @(posedge clk_in) disable iff (rst_in)
      (!parallel_mode_in && $past(parallel_mode_in) == 1'b0 && even_ld) |=>
        port_even_out == $past(sample_in, 7);
  endproperty
  a_il_steady: assert property (p_il_steady) else $error("interleaved latency not six");

  property p_par_odd_latency;
    @(posedge clk_in) disable iff (rst_in)
      (release_w && parallel_mode_in) ##1 (!sample_align_hold_in && parallel_mode_in)[*8] ##1
        (!sample_align_hold_in && parallel_mode_in) |->
        port_odd_out == $past(sample_in, 8);
  endproperty
  a_par_odd_latency: assert property (p_par_odd_latency) else $error("parallel odd latency not seven");

  property p_par_together;
    @(posedge clk_in) disable iff (rst_in)
      (parallel_mode_in && $past(parallel_mode_in) && odd_ld) |-> even_ld;
  endproperty
  a_par_together: assert property (p_par_together) else $error("parallel ports changed apart");

  property p_hold_static;
    @(posedge clk_in) disable iff (rst_in)
      sample_align_hold_in |=>
        $stable(port_even_out) && $stable(port_odd_out) && $stable(half_rate_clock_out);
  endproperty
  a_hold_static: assert property (p_hold_static) else $error("outputs switched during hold");

  property p_sync_clock;
    @(posedge clk_in) disable iff (rst_in)
      release_w |=> (half_rate_clock_out == ADOS_HCLK_AT_SYNC) && !odd_ld;
  endproperty
  a_sync_clock: assert property (p_sync_clock) else $error("sync release misaligned");

  property p_alternate;
    @(posedge clk_in) disable iff (rst_in)
      (even_ld && !parallel_mode_in) |-> !odd_ld ##1 !even_ld;
  endproperty
  a_alternate: assert property (p_alternate) else $error("ports failed to alternate");

  property p_il_odd_steady;
    @(posedge clk_in) disable iff (rst_in)
      (!parallel_mode_in && $past(parallel_mode_in) == 1'b0 && odd_ld) |=>
        port_odd_out == $past(sample_in, 7);
  endproperty
  a_il_odd_steady: assert property (p_il_odd_steady) else $error("interleaved odd latency not six");

  property p_par_even_latency;
    @(posedge clk_in) disable iff (rst_in)
      (release_w && parallel_mode_in) ##1 (!sample_align_hold_in && parallel_mode_in)[*7] |->
        port_even_out == $past(sample_in, 7);
  endproperty
  a_par_even_latency: assert property (p_par_even_latency) else $error("parallel even latency not six");

  property p_par_odd_steady;
    @(posedge clk_in) disable iff (rst_in)
      (parallel_mode_in && $past(parallel_mode_in) && odd_ld) |=> port_odd_out == $past(sample_in, 8);
  endproperty
  a_par_odd_steady: assert property (p_par_odd_steady) else $error("parallel odd word late or early");

  property p_par_even_step;
    @(posedge clk_in) disable iff (rst_in)
      (even_ld && parallel_mode_in) |=> !even_ld;
  endproperty
  a_par_even_step: assert property (p_par_even_step) else $error("parallel even port updated twice");

  property p_hold_flush;
    @(posedge clk_in) disable iff (rst_in)
      sample_align_hold_in |=> !even_ld && !odd_ld;
  endproperty
  a_hold_flush: assert property (p_hold_flush) else $error("stale word left after hold");

  property p_even_cadence;
    @(posedge clk_in) disable iff (rst_in)
      even_ld ##1 (!sample_align_hold_in)[*2] |-> even_ld;
  endproperty
  a_even_cadence: assert property (p_even_cadence) else $error("even port skipped a turn");

  property p_odd_cadence;
    @(posedge clk_in) disable iff (rst_in)
      (odd_ld && !parallel_mode_in) ##1 (!sample_align_hold_in && !parallel_mode_in)[*2] |-> odd_ld;
  endproperty
  a_odd_cadence: assert property (p_odd_cadence) else $error("odd port skipped a turn");

endmodule // ados_top

// file: test/ados_capture_model.sv
/*
  Capture logic model: latches both data ports on the rising half-rate clock.
  Assumes the ports settle before that edge, as the device keeps them in parallel mode; in interleaved mode the odd port changes on that edge.
*/
`timescale 1ns/1ps
module ados_capture_model import ados_pkg::*; (
  input wire logic hclk_in,
  input wire logic [ADOS_SAMPLE_W-1:0] even_in,
  input wire logic [ADOS_SAMPLE_W-1:0] odd_in,
  output logic [ADOS_SAMPLE_W-1:0] cap_even_out,
  output logic [ADOS_SAMPLE_W-1:0] cap_odd_out,
  output logic sync_fwd_out
);
  // Buffered capture clock, fit to drive a second converter's sync input
  assign sync_fwd_out = hclk_in;

  // A pair is taken together on one edge of the half-rate clock
  always @(posedge hclk_in) begin
    cap_even_out <= even_in;
    cap_odd_out <= odd_in;
  end
endmodule // ados_capture_model

// file: test/adc_demux_output_sync_test.sv
/*
  Bench for the demultiplexed output stage: holds, releases and streams
  counting samples in both output modes.
  Assumes a 100 MHz sample clock and the capture model beside the ports.
*/
`timescale 1ns/1ps
module adc_demux_output_sync_test;
  import ados_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADOS_SAMPLE_W-1:0] sample_in = '0;
  logic sample_align_hold_in = 1'b0;
  logic parallel_mode_in = 1'b0;
  logic [ADOS_SAMPLE_W-1:0] port_even_out, port_odd_out, cap_even, cap_odd;
  logic half_rate_clock_out, half_rate_clock_n_out;
  logic sync_fwd;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_cyc = 0;

  always #5 clk_in = ~clk_in;

  ados_top dut (.clk_in(clk_in), .rst_in(rst_in), .sample_in(sample_in),
    .sample_align_hold_in(sample_align_hold_in), .parallel_mode_in(parallel_mode_in),
    .port_even_out(port_even_out), .port_odd_out(port_odd_out),
    .half_rate_clock_out(half_rate_clock_out), .half_rate_clock_n_out(half_rate_clock_n_out));

  ados_capture_model cap (.hclk_in(half_rate_clock_out), .even_in(port_even_out),
    .odd_in(port_odd_out), .cap_even_out(cap_even), .cap_odd_out(cap_odd), .sync_fwd_out(sync_fwd));

  task print_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Cuts a hang short well after the planned run of some 80 cycles
  always @(posedge clk_in) begin
    n_cyc++;
    if (n_cyc == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task hold_check(input int len);
    logic [2*ADOS_SAMPLE_W+1:0] snap;
    @(posedge clk_in);
    #1 sample_align_hold_in = 1'b1;
    @(posedge clk_in);
    #1 snap = {port_even_out, port_odd_out, half_rate_clock_out, half_rate_clock_n_out};
    repeat (len) begin
      sample_in = sample_in + 10'h001;
      @(posedge clk_in);
      #1;
      check({port_even_out, port_odd_out, half_rate_clock_out, half_rate_clock_n_out} === snap,
        "output moved during hold");
    end
  endtask

  task stream(input logic par, input int len);
    int k;
    int lo;
    logic [ADOS_SAMPLE_W-1:0] b;
    b = 10'h100 + 10'(len * 16);
    lo = 7 + int'(par);
    parallel_mode_in = par;
    hold_check(len);
    sample_align_hold_in = 1'b0;
    sample_in = b;
    for (k = 0; k < 14; k++) begin
      @(posedge clk_in);
      #1 sample_in = b + 10'(k + 1);
      check(half_rate_clock_out === k[0] && half_rate_clock_n_out === !k[0], "half-rate clock");
      check(sync_fwd === k[0], "forwarded sync clock");
      if (k >= 6)
        check(port_even_out === b + 10'((k - 6) & ~1), "even port");
      if (k >= lo)
        check(port_odd_out === b + 10'(((k - lo) & ~1) + 1), "odd port");
      if (par && k >= 9 && k[0])
        check(cap_even === cap_odd + 10'h001, "captured pair");
      if (par && k >= 9 && k[0])
        check(cap_even === b + 10'(k - 7), "even-only capture");
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    check(port_even_out === '0 && port_odd_out === '0 && half_rate_clock_out === 1'b0
      && half_rate_clock_n_out === 1'b1, "reset state");
    rst_in = 1'b0;
    stream(1'b0, 3);
    stream(1'b1, 4);
    stream(1'b0, 4);
    print_verdict();
  end
endmodule // adc_demux_output_sync_test
